// ==== pkg/ccod_defs.vh ====
/*
  constants of the opcode decoder: operation codes, operand modes,
  instruction lengths, machine-cycle counts and flag mask bits.
  assumes it is included by bare name from the core/ files.
*/
`ifndef CCOD_DEFS_VH
`define CCOD_DEFS_VH

// ------------------------------------------------------------
// lengths, cycles, extension select
// ------------------------------------------------------------
`define CCOD_L1 2'h1
`define CCOD_L2 2'h2
`define CCOD_L3 2'h3
`define CCOD_C1 3'h1
`define CCOD_C2 3'h2
`define CCOD_C4 3'h4
`define CCOD_EXT_STORE 4'h1
`define CCOD_EXT_TRAP 4'h2
`define CCOD_FL_CY 2
`define CCOD_FL_AC 1
`define CCOD_FL_OV 0

// ------------------------------------------------------------
// operand modes
// ------------------------------------------------------------
`define CCOD_AM_NONE 4'h0
`define CCOD_AM_A 4'h1
`define CCOD_AM_RN 4'h2
`define CCOD_AM_DIR 4'h3
`define CCOD_AM_IND 4'h4
`define CCOD_AM_IMM 4'h5
`define CCOD_AM_BIT 4'h6
`define CCOD_AM_C 4'h7
`define CCOD_AM_DPTR 4'h8
`define CCOD_AM_PC 4'h9
`define CCOD_AM_A11 4'ha
`define CCOD_AM_A16 4'hb
`define CCOD_AM_REL 4'hc
`define CCOD_AM_AB 4'hd

// ------------------------------------------------------------
// operations
// ------------------------------------------------------------
`define CCOD_OP_NOP 6'h00
`define CCOD_OP_AJMP 6'h01
`define CCOD_OP_ACALL 6'h02
`define CCOD_OP_LJMP 6'h03
`define CCOD_OP_LCALL 6'h04
`define CCOD_OP_RR 6'h05
`define CCOD_OP_RRC 6'h06
`define CCOD_OP_RL 6'h07
`define CCOD_OP_RLC 6'h08
`define CCOD_OP_INC 6'h09
`define CCOD_OP_DEC 6'h0a
`define CCOD_OP_ADD 6'h0b
`define CCOD_OP_ADDC 6'h0c
`define CCOD_OP_SUBB 6'h0d
`define CCOD_OP_MUL 6'h0e
`define CCOD_OP_DIV 6'h0f
`define CCOD_OP_DA 6'h10
`define CCOD_OP_ANL 6'h11
`define CCOD_OP_ORL 6'h12
`define CCOD_OP_XRL 6'h13
`define CCOD_OP_CLR 6'h14
`define CCOD_OP_CPL 6'h15
`define CCOD_OP_SWAP 6'h16
`define CCOD_OP_SETB 6'h17
`define CCOD_OP_JBC 6'h18
`define CCOD_OP_JB 6'h19
`define CCOD_OP_JNB 6'h1a
`define CCOD_OP_JC 6'h1b
`define CCOD_OP_JNC 6'h1c
`define CCOD_OP_JZ 6'h1d
`define CCOD_OP_JNZ 6'h1e
`define CCOD_OP_SJMP 6'h1f
`define CCOD_OP_JMPI 6'h20
`define CCOD_OP_RET 6'h21
`define CCOD_OP_RETI 6'h22
`define CCOD_OP_ANLC 6'h23
`define CCOD_OP_ANLCN 6'h24
`define CCOD_OP_ORLC 6'h25
`define CCOD_OP_ORLCN 6'h26
`define CCOD_OP_MOVCB 6'h27
`define CCOD_OP_MOVBC 6'h28
`define CCOD_OP_MOV 6'h29
`define CCOD_OP_MOVC 6'h2a
`define CCOD_OP_MOVXR 6'h2b
`define CCOD_OP_MOVXW 6'h2c
`define CCOD_OP_PUSH 6'h2d
`define CCOD_OP_POP 6'h2e
`define CCOD_OP_XCH 6'h2f
`define CCOD_OP_XCHD 6'h30
`define CCOD_OP_CJNE 6'h31
`define CCOD_OP_DJNZ 6'h32
`define CCOD_OP_PSTORE 6'h33
`define CCOD_OP_TRAP 6'h34
`define CCOD_OP_RSVD 6'h35

`endif

// ==== core/ccod_fields.v ====
/*
  operand fields carried inside the opcode byte itself.
  assumes the opcode is stable while the decoder samples it.
*/
`timescale 1ns/1ns
`include "ccod_defs.vh"

module ccod_fields
(
  input  wire [7:0] opcode,
  output wire [2:0] reg_idx,
  output wire       ind_idx,
  output wire [2:0] abs_hi
);

  assign reg_idx = opcode[2:0];
  assign ind_idx = opcode[0];
  // the eight 11-bit pages are spread over non-contiguous opcodes
  assign abs_hi = opcode[7:5];

endmodule // ccod_fields

// ==== core/ccod_mc_seq.v ====
/*
  machine-cycle sequencer: holds busy for two clock periods per cycle.
  assumes start only arrives while busy is low.
*/
`timescale 1ns/1ns
`include "ccod_defs.vh"

module ccod_mc_seq
(
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       start,
  input  wire [2:0] cycles,
  output wire       busy,
  output wire       done
);

  reg       busy_r;
  reg       phase_r;
  reg [2:0] mc_cnt_r;
  reg [2:0] mc_last_r;
  reg       done_r;

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r    <= 1'b0;
      phase_r   <= 1'b0;
      mc_cnt_r  <= 3'h0;
      mc_last_r <= 3'h0;
      done_r    <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start)
      begin
        busy_r    <= 1'b1;
        phase_r   <= 1'b0;
        mc_cnt_r  <= 3'h0;
        mc_last_r <= cycles - `CCOD_C1;
      end
      else if (busy_r)
      begin
        phase_r <= ~phase_r;
        if (phase_r)
        begin
          mc_cnt_r <= mc_cnt_r + `CCOD_C1;
          if (mc_cnt_r == mc_last_r)
          begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule // ccod_mc_seq

// ==== core/ccod_decoder.v ====
/*
  opcode decoder of the 8-bit cisc core: operation, operand mode,
  length, cycle count, flag update mask and in-opcode fields.
  assumes the fetch path offers one opcode byte with op_valid and
  holds it until op_ready; extension select is static while offered.
*/
`timescale 1ns/1ns
`include "ccod_defs.vh"

module ccod_decoder
(
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       op_valid,
  input  wire [7:0] op_byte,
  input  wire [3:0] extended_opcode_select,
  output wire       op_ready,
  output reg        dec_valid,
  output reg  [5:0] dec_op,
  output reg  [3:0] dec_src,
  output reg  [1:0] dec_len,
  output reg  [2:0] dec_cycles,
  output reg  [2:0] dec_reg_idx,
  output reg        dec_ind_idx,
  output reg  [2:0] dec_abs_hi,
  output reg  [2:0] dec_flag_upd,
  output reg        dec_branch,
  output reg        dec_rsvd,
  output wire       exec_busy,
  output wire       exec_done
);

  // ------------------------------------------------------------
  // internal signals
  // ------------------------------------------------------------
  reg  [5:0] op_nxt;
  reg  [3:0] src_nxt;
  reg  [1:0] len_nxt;
  reg  [2:0] cyc_nxt;
  reg  [2:0] flag_nxt;
  reg        branch_nxt;
  wire       accept;
  wire [2:0] fld_reg;
  wire       fld_ind;
  wire [2:0] fld_abs;

  assign op_ready = ~exec_busy;
  assign accept   = op_valid & op_ready;

  // ------------------------------------------------------------
  // operand fields and machine-cycle sequencing
  // ------------------------------------------------------------
  ccod_fields u_fields
  (
    .opcode  (op_byte),
    .reg_idx (fld_reg),
    .ind_idx (fld_ind),
    .abs_hi  (fld_abs)
  );

  ccod_mc_seq u_seq
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (accept),
    .cycles  (cyc_nxt),
    .busy    (exec_busy),
    .done    (exec_done)
  );

  // ------------------------------------------------------------
  // opcode table
  // ------------------------------------------------------------
  task d;
    input [5:0] op;
    input [1:0] len;
    input [2:0] cyc;
    input [3:0] src;
    begin
      op_nxt  = op;
      len_nxt = len;
      cyc_nxt = cyc;
      src_nxt = src;
    end
  endtask

  always @*
  begin
    op_nxt  = `CCOD_OP_RSVD;
    len_nxt = `CCOD_L1;
    cyc_nxt = `CCOD_C1;
    src_nxt = `CCOD_AM_NONE;
    casez (op_byte)
      8'h00: d(`CCOD_OP_NOP, `CCOD_L1, `CCOD_C1, `CCOD_AM_NONE);
      8'b???0_0001: d(`CCOD_OP_AJMP, `CCOD_L2, `CCOD_C2, `CCOD_AM_A11);
      8'b???1_0001: d(`CCOD_OP_ACALL, `CCOD_L2, `CCOD_C2, `CCOD_AM_A11);
      8'h02: d(`CCOD_OP_LJMP, `CCOD_L3, `CCOD_C2, `CCOD_AM_A16);
      8'h03: d(`CCOD_OP_RR, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'h04: d(`CCOD_OP_INC, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'h05: d(`CCOD_OP_INC, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0000_011?: d(`CCOD_OP_INC, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0000_1???: d(`CCOD_OP_INC, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h10: d(`CCOD_OP_JBC, `CCOD_L3, `CCOD_C2, `CCOD_AM_BIT);
      8'h12: d(`CCOD_OP_LCALL, `CCOD_L3, `CCOD_C2, `CCOD_AM_A16);
      8'h13: d(`CCOD_OP_RRC, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'h14: d(`CCOD_OP_DEC, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'h15: d(`CCOD_OP_DEC, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0001_011?: d(`CCOD_OP_DEC, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0001_1???: d(`CCOD_OP_DEC, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h20: d(`CCOD_OP_JB, `CCOD_L3, `CCOD_C2, `CCOD_AM_BIT);
      8'h22: d(`CCOD_OP_RET, `CCOD_L1, `CCOD_C2, `CCOD_AM_NONE);
      8'h23: d(`CCOD_OP_RL, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'h24: d(`CCOD_OP_ADD, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h25: d(`CCOD_OP_ADD, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0010_011?: d(`CCOD_OP_ADD, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0010_1???: d(`CCOD_OP_ADD, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h30: d(`CCOD_OP_JNB, `CCOD_L3, `CCOD_C2, `CCOD_AM_BIT);
      8'h32: d(`CCOD_OP_RETI, `CCOD_L1, `CCOD_C2, `CCOD_AM_NONE);
      8'h33: d(`CCOD_OP_RLC, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'h34: d(`CCOD_OP_ADDC, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h35: d(`CCOD_OP_ADDC, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0011_011?: d(`CCOD_OP_ADDC, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0011_1???: d(`CCOD_OP_ADDC, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h40: d(`CCOD_OP_JC, `CCOD_L2, `CCOD_C2, `CCOD_AM_REL);
      8'h42: d(`CCOD_OP_ORL, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'h43: d(`CCOD_OP_ORL, `CCOD_L3, `CCOD_C2, `CCOD_AM_IMM);
      8'h44: d(`CCOD_OP_ORL, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h45: d(`CCOD_OP_ORL, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0100_011?: d(`CCOD_OP_ORL, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0100_1???: d(`CCOD_OP_ORL, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h50: d(`CCOD_OP_JNC, `CCOD_L2, `CCOD_C2, `CCOD_AM_REL);
      8'h52: d(`CCOD_OP_ANL, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'h53: d(`CCOD_OP_ANL, `CCOD_L3, `CCOD_C2, `CCOD_AM_IMM);
      8'h54: d(`CCOD_OP_ANL, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h55: d(`CCOD_OP_ANL, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0101_011?: d(`CCOD_OP_ANL, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0101_1???: d(`CCOD_OP_ANL, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h60: d(`CCOD_OP_JZ, `CCOD_L2, `CCOD_C2, `CCOD_AM_REL);
      8'h62: d(`CCOD_OP_XRL, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'h63: d(`CCOD_OP_XRL, `CCOD_L3, `CCOD_C2, `CCOD_AM_IMM);
      8'h64: d(`CCOD_OP_XRL, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h65: d(`CCOD_OP_XRL, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b0110_011?: d(`CCOD_OP_XRL, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b0110_1???: d(`CCOD_OP_XRL, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'h70: d(`CCOD_OP_JNZ, `CCOD_L2, `CCOD_C2, `CCOD_AM_REL);
      8'h72: d(`CCOD_OP_ORLC, `CCOD_L2, `CCOD_C2, `CCOD_AM_BIT);
      8'h73: d(`CCOD_OP_JMPI, `CCOD_L1, `CCOD_C2, `CCOD_AM_DPTR);
      8'h74: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h75: d(`CCOD_OP_MOV, `CCOD_L3, `CCOD_C2, `CCOD_AM_IMM);
      8'b0111_011?: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'b0111_1???: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h80: d(`CCOD_OP_SJMP, `CCOD_L2, `CCOD_C2, `CCOD_AM_REL);
      8'h82: d(`CCOD_OP_ANLC, `CCOD_L2, `CCOD_C2, `CCOD_AM_BIT);
      8'h83: d(`CCOD_OP_MOVC, `CCOD_L1, `CCOD_C2, `CCOD_AM_PC);
      8'h84: d(`CCOD_OP_DIV, `CCOD_L1, `CCOD_C4, `CCOD_AM_AB);
      8'h85: d(`CCOD_OP_MOV, `CCOD_L3, `CCOD_C2, `CCOD_AM_DIR);
      8'b1000_011?: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C2, `CCOD_AM_IND);
      8'b1000_1???: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C2, `CCOD_AM_RN);
      8'h90: d(`CCOD_OP_MOV, `CCOD_L3, `CCOD_C2, `CCOD_AM_IMM);
      8'h92: d(`CCOD_OP_MOVBC, `CCOD_L2, `CCOD_C2, `CCOD_AM_C);
      8'h93: d(`CCOD_OP_MOVC, `CCOD_L1, `CCOD_C2, `CCOD_AM_DPTR);
      8'h94: d(`CCOD_OP_SUBB, `CCOD_L2, `CCOD_C1, `CCOD_AM_IMM);
      8'h95: d(`CCOD_OP_SUBB, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b1001_011?: d(`CCOD_OP_SUBB, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b1001_1???: d(`CCOD_OP_SUBB, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'ha0: d(`CCOD_OP_ORLCN, `CCOD_L2, `CCOD_C2, `CCOD_AM_BIT);
      8'ha2: d(`CCOD_OP_MOVCB, `CCOD_L2, `CCOD_C1, `CCOD_AM_BIT);
      8'ha3: d(`CCOD_OP_INC, `CCOD_L1, `CCOD_C2, `CCOD_AM_DPTR);
      8'ha4: d(`CCOD_OP_MUL, `CCOD_L1, `CCOD_C4, `CCOD_AM_AB);
      8'ha5:
      begin
        // without a selection a5 stays reserved rather than guessing
        if (extended_opcode_select == `CCOD_EXT_STORE)
          d(`CCOD_OP_PSTORE, `CCOD_L1, `CCOD_C2, `CCOD_AM_DPTR);
        else if (extended_opcode_select == `CCOD_EXT_TRAP)
          d(`CCOD_OP_TRAP, `CCOD_L1, `CCOD_C1, `CCOD_AM_NONE);
        else
          d(`CCOD_OP_RSVD, `CCOD_L1, `CCOD_C1, `CCOD_AM_NONE);
      end
      8'b1010_011?: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C2, `CCOD_AM_DIR);
      8'b1010_1???: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C2, `CCOD_AM_DIR);
      8'hb0: d(`CCOD_OP_ANLCN, `CCOD_L2, `CCOD_C2, `CCOD_AM_BIT);
      8'hb2: d(`CCOD_OP_CPL, `CCOD_L2, `CCOD_C1, `CCOD_AM_BIT);
      8'hb3: d(`CCOD_OP_CPL, `CCOD_L1, `CCOD_C1, `CCOD_AM_C);
      8'hb4: d(`CCOD_OP_CJNE, `CCOD_L3, `CCOD_C2, `CCOD_AM_IMM);
      8'hb5: d(`CCOD_OP_CJNE, `CCOD_L3, `CCOD_C2, `CCOD_AM_DIR);
      8'b1011_011?: d(`CCOD_OP_CJNE, `CCOD_L3, `CCOD_C2, `CCOD_AM_IND);
      8'b1011_1???: d(`CCOD_OP_CJNE, `CCOD_L3, `CCOD_C2, `CCOD_AM_RN);
      8'hc0: d(`CCOD_OP_PUSH, `CCOD_L2, `CCOD_C2, `CCOD_AM_DIR);
      8'hc2: d(`CCOD_OP_CLR, `CCOD_L2, `CCOD_C1, `CCOD_AM_BIT);
      8'hc3: d(`CCOD_OP_CLR, `CCOD_L1, `CCOD_C1, `CCOD_AM_C);
      8'hc4: d(`CCOD_OP_SWAP, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'hc5: d(`CCOD_OP_XCH, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b1100_011?: d(`CCOD_OP_XCH, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b1100_1???: d(`CCOD_OP_XCH, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'hd0: d(`CCOD_OP_POP, `CCOD_L2, `CCOD_C2, `CCOD_AM_DIR);
      8'hd2: d(`CCOD_OP_SETB, `CCOD_L2, `CCOD_C1, `CCOD_AM_BIT);
      8'hd3: d(`CCOD_OP_SETB, `CCOD_L1, `CCOD_C1, `CCOD_AM_C);
      8'hd4: d(`CCOD_OP_DA, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'hd5: d(`CCOD_OP_DJNZ, `CCOD_L3, `CCOD_C2, `CCOD_AM_DIR);
      8'b1101_011?: d(`CCOD_OP_XCHD, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b1101_1???: d(`CCOD_OP_DJNZ, `CCOD_L3, `CCOD_C2, `CCOD_AM_RN);
      8'he0: d(`CCOD_OP_MOVXR, `CCOD_L1, `CCOD_C2, `CCOD_AM_DPTR);
      8'b1110_001?: d(`CCOD_OP_MOVXR, `CCOD_L1, `CCOD_C2, `CCOD_AM_IND);
      8'he4: d(`CCOD_OP_CLR, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'he5: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C1, `CCOD_AM_DIR);
      8'b1110_011?: d(`CCOD_OP_MOV, `CCOD_L1, `CCOD_C1, `CCOD_AM_IND);
      8'b1110_1???: d(`CCOD_OP_MOV, `CCOD_L1, `CCOD_C1, `CCOD_AM_RN);
      8'hf0: d(`CCOD_OP_MOVXW, `CCOD_L1, `CCOD_C2, `CCOD_AM_DPTR);
      8'b1111_001?: d(`CCOD_OP_MOVXW, `CCOD_L1, `CCOD_C2, `CCOD_AM_IND);
      8'hf4: d(`CCOD_OP_CPL, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'hf5: d(`CCOD_OP_MOV, `CCOD_L2, `CCOD_C1, `CCOD_AM_A);
      8'b1111_011?: d(`CCOD_OP_MOV, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      8'b1111_1???: d(`CCOD_OP_MOV, `CCOD_L1, `CCOD_C1, `CCOD_AM_A);
      default: d(`CCOD_OP_RSVD, `CCOD_L1, `CCOD_C1, `CCOD_AM_NONE);
    endcase
  end

  // ------------------------------------------------------------
  // flag update mask and branch class
  // ------------------------------------------------------------
  // only the carry-targeting forms of clr/setb/cpl touch cy, so the
  // operand mode is checked along with the operation
  always @*
  begin
    flag_nxt = 3'h0;
    case (op_nxt)
      `CCOD_OP_ADD, `CCOD_OP_ADDC, `CCOD_OP_SUBB:
      begin
        flag_nxt[`CCOD_FL_CY] = 1'b1;
        flag_nxt[`CCOD_FL_AC] = 1'b1;
        flag_nxt[`CCOD_FL_OV] = 1'b1;
      end
      `CCOD_OP_MUL, `CCOD_OP_DIV:
      begin
        flag_nxt[`CCOD_FL_CY] = 1'b1;
        flag_nxt[`CCOD_FL_OV] = 1'b1;
      end
      `CCOD_OP_DA, `CCOD_OP_RLC, `CCOD_OP_RRC, `CCOD_OP_CJNE,
      `CCOD_OP_ANLC, `CCOD_OP_ANLCN, `CCOD_OP_ORLC, `CCOD_OP_ORLCN,
      `CCOD_OP_MOVCB:
        flag_nxt[`CCOD_FL_CY] = 1'b1;
      `CCOD_OP_CLR, `CCOD_OP_SETB, `CCOD_OP_CPL:
        flag_nxt[`CCOD_FL_CY] = (src_nxt == `CCOD_AM_C);
      default:
        flag_nxt = 3'h0;
    endcase
  end

  always @*
  begin
    case (op_nxt)
      `CCOD_OP_AJMP, `CCOD_OP_ACALL, `CCOD_OP_LJMP, `CCOD_OP_LCALL,
      `CCOD_OP_SJMP, `CCOD_OP_JMPI, `CCOD_OP_RET, `CCOD_OP_RETI,
      `CCOD_OP_JC, `CCOD_OP_JNC, `CCOD_OP_JB, `CCOD_OP_JNB,
      `CCOD_OP_JBC, `CCOD_OP_JZ, `CCOD_OP_JNZ, `CCOD_OP_CJNE,
      `CCOD_OP_DJNZ:
        branch_nxt = 1'b1;
      default:
        branch_nxt = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // decoded outputs, captured on acceptance
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dec_valid    <= 1'b0;
      dec_op       <= `CCOD_OP_NOP;
      dec_src      <= `CCOD_AM_NONE;
      dec_len      <= `CCOD_L1;
      dec_cycles   <= `CCOD_C1;
      dec_reg_idx  <= 3'h0;
      dec_ind_idx  <= 1'b0;
      dec_abs_hi   <= 3'h0;
      dec_flag_upd <= 3'h0;
      dec_branch   <= 1'b0;
      dec_rsvd     <= 1'b0;
    end
    else
    begin
      dec_valid <= accept;
      if (accept)
      begin
        dec_op       <= op_nxt;
        dec_src      <= src_nxt;
        dec_len      <= len_nxt;
        dec_cycles   <= cyc_nxt;
        dec_reg_idx  <= fld_reg;
        dec_ind_idx  <= fld_ind;
        dec_abs_hi   <= fld_abs;
        dec_flag_upd <= flag_nxt;
        dec_branch   <= branch_nxt;
        dec_rsvd     <= (op_nxt == `CCOD_OP_RSVD);
      end
    end
  end

endmodule // ccod_decoder

// ==== tb/ccod_monitor.sv ====
/*
  concurrent checks on the opcode decoder ports.
  assumes one clock domain on ref_clk and rstn asynchronous, active low.
*/
`timescale 1ns/1ns
`include "ccod_defs.vh"

module ccod_monitor
(
  input logic       ref_clk,
  input logic       rstn,
  input logic       op_valid,
  input logic [7:0] op_byte,
  input logic       op_ready,
  input logic       dec_valid,
  input logic [5:0] dec_op,
  input logic [1:0] dec_len,
  input logic [2:0] dec_cycles,
  input logic [2:0] dec_reg_idx,
  input logic [2:0] dec_flag_upd,
  input logic       exec_busy,
  input logic       exec_done
);
  logic [7:0] byte_d;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // byte seen at the accepting edge, which the decode fields must reflect
  always @(posedge ref_clk)
  begin
    byte_d <= op_byte;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_run1; exec_busy [*2] ##1 (exec_done && !exec_busy); endsequence
  sequence s_run2; exec_busy [*4] ##1 (exec_done && !exec_busy); endsequence
  sequence s_run4; exec_busy [*8] ##1 (exec_done && !exec_busy); endsequence

  property p_accept; op_valid && op_ready |=> dec_valid && exec_busy; endproperty
  property p_idle; !(op_valid && op_ready) |=> !dec_valid; endproperty
  property p_range;
    dec_valid |-> dec_len inside {2'h1, 2'h2, 2'h3} && dec_cycles inside {3'h1, 3'h2, 3'h4};
  endproperty
  property p_hold; !dec_valid |-> $stable(dec_op) && $stable(dec_len) && $stable(dec_cycles);
  endproperty
  property p_ready; op_ready == !exec_busy; endproperty
  property p_run1; dec_valid && dec_cycles == 3'h1 |-> s_run1; endproperty
  property p_run2; dec_valid && dec_cycles == 3'h2 |-> s_run2; endproperty
  property p_run4; dec_valid && dec_cycles == 3'h4 |-> s_run4; endproperty
  property p_reg; dec_valid |-> dec_reg_idx == byte_d[2:0]; endproperty
  property p_arith;
    dec_valid && dec_op inside {`CCOD_OP_ADD, `CCOD_OP_ADDC, `CCOD_OP_SUBB}
      |-> dec_flag_upd == 3'h7;
  endproperty
  property p_logic;
    dec_valid && dec_op inside {`CCOD_OP_ANL, `CCOD_OP_ORL, `CCOD_OP_XRL, `CCOD_OP_MOV}
      |-> dec_flag_upd == 3'h0;
  endproperty

  a_accept: assert property (p_accept) else $error("accept without decode");
  a_idle: assert property (p_idle) else $error("decode without accept");
  a_range: assert property (p_range) else $error("length or cycles out of set");
  a_hold: assert property (p_hold) else $error("fields moved between decodes");
  a_ready: assert property (p_ready) else $error("ready not inverse of busy");
  a_run1: assert property (p_run1) else $error("one cycle run length wrong");
  a_run2: assert property (p_run2) else $error("two cycle run length wrong");
  a_run4: assert property (p_run4) else $error("four cycle run length wrong");
  a_reg: assert property (p_reg) else $error("register index wrong");
  a_arith: assert property (p_arith) else $error("arith flag mask wrong");
  a_logic: assert property (p_logic) else $error("logic flag mask wrong");
endmodule // ccod_monitor

bind ccod_decoder ccod_monitor ccod_monitor_inst
(
  .ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid), .op_byte(op_byte),
  .op_ready(op_ready), .dec_valid(dec_valid), .dec_op(dec_op), .dec_len(dec_len),
  .dec_cycles(dec_cycles), .dec_reg_idx(dec_reg_idx), .dec_flag_upd(dec_flag_upd),
  .exec_busy(exec_busy), .exec_done(exec_done)
);

// ==== tb/ccod_fetch_model.sv ====
/*
  fetch path model: offers one opcode byte per push, holds it until taken.
  assumes push arrives only while no byte is pending.
*/
`timescale 1ns/1ns

module ccod_fetch_model
(
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       push,
  input  wire [7:0] push_byte,
  input  wire       op_ready,
  output reg        op_valid,
  output reg  [7:0] op_byte
);
  // ------------------------------------------------------------
  // offer
  // ------------------------------------------------------------
  // a released lane shows the inverse byte, so a late sample never matches
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_valid <= 1'b0;
      op_byte  <= 8'h00;
    end
    else if (op_valid && op_ready)
    begin
      op_valid <= 1'b0;
      op_byte  <= ~op_byte;
    end
    else if (push)
    begin
      op_valid <= 1'b1;
      op_byte  <= push_byte;
    end
  end
endmodule // ccod_fetch_model

// ==== tb/testbench.sv ====
/*
  self-checking bench of the opcode decoder: table of opcodes, then
  extension, refusal while busy and mid-run reset.
  assumes the fetch model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`include "ccod_defs.vh"

module testbench;
  typedef struct packed
  {
    logic [7:0] b;
    logic [5:0] op;
    logic [1:0] len;
    logic [2:0] cyc;
  } ccod_row_t;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       push = 1'b0;
  logic [7:0] push_byte = 8'h00;
  logic [3:0] ext_sel = 4'h0;
  logic       op_valid, op_ready, dec_valid, dec_rsvd, exec_busy, exec_done;
  logic       dec_ind_idx, dec_branch;
  logic [3:0] dec_src;
  logic [7:0] op_byte;
  logic [5:0] dec_op;
  logic [1:0] dec_len;
  logic [2:0] dec_cycles, dec_reg_idx, dec_abs_hi, dec_flag_upd;
  integer     err_count = 0;
  integer     comparisons = 0;
  integer     i, n;
  ccod_row_t  rows [0:43] = '{
    '{8'h2f,`CCOD_OP_ADD,2'h1,3'h1}, '{8'h26,`CCOD_OP_ADD,2'h1,3'h1},
    '{8'h24,`CCOD_OP_ADD,2'h2,3'h1}, '{8'h38,`CCOD_OP_ADDC,2'h1,3'h1},
    '{8'h35,`CCOD_OP_ADDC,2'h2,3'h1}, '{8'h9f,`CCOD_OP_SUBB,2'h1,3'h1},
    '{8'h94,`CCOD_OP_SUBB,2'h2,3'h1}, '{8'h0f,`CCOD_OP_INC,2'h1,3'h1},
    '{8'h05,`CCOD_OP_INC,2'h2,3'h1}, '{8'h14,`CCOD_OP_DEC,2'h1,3'h1},
    '{8'h17,`CCOD_OP_DEC,2'h1,3'h1}, '{8'ha3,`CCOD_OP_INC,2'h1,3'h2},
    '{8'ha4,`CCOD_OP_MUL,2'h1,3'h4}, '{8'h84,`CCOD_OP_DIV,2'h1,3'h4},
    '{8'h53,`CCOD_OP_ANL,2'h3,3'h2}, '{8'h5f,`CCOD_OP_ANL,2'h1,3'h1},
    '{8'h43,`CCOD_OP_ORL,2'h3,3'h2}, '{8'h42,`CCOD_OP_ORL,2'h2,3'h1},
    '{8'h63,`CCOD_OP_XRL,2'h3,3'h2}, '{8'h68,`CCOD_OP_XRL,2'h1,3'h1},
    '{8'hc4,`CCOD_OP_SWAP,2'h1,3'h1}, '{8'h33,`CCOD_OP_RLC,2'h1,3'h1},
    '{8'h13,`CCOD_OP_RRC,2'h1,3'h1}, '{8'he4,`CCOD_OP_CLR,2'h1,3'h1},
    '{8'he8,`CCOD_OP_MOV,2'h1,3'h1}, '{8'hff,`CCOD_OP_MOV,2'h1,3'h1},
    '{8'ha8,`CCOD_OP_MOV,2'h2,3'h2}, '{8'h85,`CCOD_OP_MOV,2'h3,3'h2},
    '{8'h75,`CCOD_OP_MOV,2'h3,3'h2}, '{8'h93,`CCOD_OP_MOVC,2'h1,3'h2},
    '{8'h83,`CCOD_OP_MOVC,2'h1,3'h2}, '{8'he2,`CCOD_OP_MOVXR,2'h1,3'h2},
    '{8'hf0,`CCOD_OP_MOVXW,2'h1,3'h2}, '{8'hb0,`CCOD_OP_ANLCN,2'h2,3'h2},
    '{8'ha0,`CCOD_OP_ORLCN,2'h2,3'h2}, '{8'h12,`CCOD_OP_LCALL,2'h3,3'h2},
    '{8'h22,`CCOD_OP_RET,2'h1,3'h2}, '{8'h10,`CCOD_OP_JBC,2'h3,3'h2},
    '{8'h50,`CCOD_OP_JNC,2'h2,3'h2}, '{8'hb4,`CCOD_OP_CJNE,2'h3,3'h2},
    '{8'hd8,`CCOD_OP_DJNZ,2'h3,3'h2}, '{8'he1,`CCOD_OP_AJMP,2'h2,3'h2},
    '{8'hf1,`CCOD_OP_ACALL,2'h2,3'h2}, '{8'h82,`CCOD_OP_ANLC,2'h2,3'h2}
  };

  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;

  ccod_fetch_model ccod_fetch_model_inst (.ref_clk(ref_clk), .rstn(rstn), .push(push),
    .push_byte(push_byte), .op_ready(op_ready), .op_valid(op_valid), .op_byte(op_byte));
  ccod_decoder ccod_decoder_inst (.ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid),
    .op_byte(op_byte), .extended_opcode_select(ext_sel), .op_ready(op_ready),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_src(dec_src), .dec_len(dec_len),
    .dec_cycles(dec_cycles), .dec_reg_idx(dec_reg_idx), .dec_ind_idx(dec_ind_idx),
    .dec_abs_hi(dec_abs_hi), .dec_flag_upd(dec_flag_upd), .dec_branch(dec_branch),
    .dec_rsvd(dec_rsvd), .exec_busy(exec_busy), .exec_done(exec_done));

  function automatic logic [2:0] flag_exp(input logic [5:0] op);
    case (op)
      `CCOD_OP_ADD, `CCOD_OP_ADDC, `CCOD_OP_SUBB: flag_exp = 3'h7;
      `CCOD_OP_MUL, `CCOD_OP_DIV: flag_exp = 3'h5;
      `CCOD_OP_RLC, `CCOD_OP_RRC, `CCOD_OP_CJNE, `CCOD_OP_ANLC: flag_exp = 3'h4;
      `CCOD_OP_ANLCN, `CCOD_OP_ORLCN: flag_exp = 3'h4;
      default: flag_exp = 3'h0;
    endcase
  endfunction

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tick;
    @(posedge ref_clk);
    #2;
  endtask

  // offer a byte, then wait bounded for its decode pulse
  task offer(input logic [7:0] b);
    push = 1'b1;
    push_byte = b;
    tick;
    push = 1'b0;
    n = 0;
    while (dec_valid !== 1'b1 && n < 20)
    begin
      tick;
      n = n + 1;
    end
    chk(dec_valid, 8'h01);
  endtask

  task finish(input logic [2:0] cyc);
    n = 0;
    while (exec_done !== 1'b1 && n < 20)
    begin
      tick;
      n = n + 1;
    end
    chk(n[7:0], {4'h0, cyc, 1'b0});
  endtask

  task tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_count = err_count + 1;
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    tick;
    chk(dec_op, `CCOD_OP_NOP);
    chk(op_ready, 8'h01);
    for (i = 0; i < 44; i = i + 1)
    begin
      offer(rows[i].b);
      chk(dec_op, rows[i].op);
      chk({dec_len, dec_cycles}, {rows[i].len, rows[i].cyc});
      chk(dec_reg_idx, rows[i].b[2:0]);
      chk(dec_ind_idx, rows[i].b[0]);
      chk(dec_branch, rows[i].op inside {`CCOD_OP_AJMP, `CCOD_OP_ACALL, `CCOD_OP_LCALL,
        `CCOD_OP_RET, `CCOD_OP_JBC, `CCOD_OP_JNC, `CCOD_OP_CJNE, `CCOD_OP_DJNZ});
      chk(dec_abs_hi, rows[i].b[7:5]);
      chk(dec_flag_upd, flag_exp(rows[i].op));
      finish(rows[i].cyc);
    end
    // fields hold after the run: the last row is a carry-with-bit form
    chk(dec_src, `CCOD_AM_BIT);
    for (i = 0; i < 3; i = i + 1)
    begin
      ext_sel = i[3:0];
      offer(8'ha5);
      chk(dec_op, ext_sel == `CCOD_EXT_STORE ? `CCOD_OP_PSTORE :
        ext_sel == `CCOD_EXT_TRAP ? `CCOD_OP_TRAP : `CCOD_OP_RSVD);
      chk(dec_rsvd, i == 0);
      finish(ext_sel == `CCOD_EXT_STORE ? 3'h2 : 3'h1);
    end
    // second byte offered while busy: refused until the 8-clock run ends
    offer(8'h84);
    offer(8'h00);
    chk(n[7:0], 8'h08);
    finish(3'h1);
    offer(8'ha4);
    tick;
    rstn = 1'b0;
    #2;
    chk({exec_busy, op_ready}, 8'h01);
    chk(dec_op, `CCOD_OP_NOP);
    tick;
    rstn = 1'b1;
    offer(8'h00);
    finish(3'h1);
    tally_and_finish;
  end
endmodule // testbench
